/* File: rtl/ddcl_pkg.sv */
// Package: register map, field positions, reset values, modes and timing of the DDC link
package ddcl_pkg;
    // Register byte offsets (one 32-bit word each)
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_CLKSEL  = 8'h04;
    localparam logic [7:0] OFS_TXDATA  = 8'h08;
    localparam logic [7:0] OFS_IRQSTAT = 8'h0c;
    localparam logic [7:0] OFS_IRQEN   = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;

    // channel_control_reg fields
    localparam int CTRL_SYNC_SEP = 0;
    localparam int CTRL_GPIO_SDA = 1;
    localparam int CTRL_GPIO_SCL = 2;
    localparam int CTRL_RETURN   = 6;
    localparam int CTRL_ENABLE_N = 7;
    // channel_clock_reg fields
    localparam int CLK_MASTER_N  = 7;
    // Interrupt status and irq_enable_reg fields
    localparam int IRQ_TX        = 0;
    localparam int IRQ_SCL       = 1;
    // Status register fields
    localparam int ST_MODE_LO    = 0;
    localparam int ST_SDA_IN     = 4;
    localparam int ST_SCL_IN     = 5;

    // Reset values
    localparam logic [7:0] CTRL_RST    = 8'h81;
    localparam logic [7:0] CLKSEL_RST  = 8'hff;
    localparam logic [7:0] TXDATA_RST  = 8'h00;
    localparam logic [1:0] IRQ_RST     = 2'h0;
    localparam logic [8:0] SHIFT_RST   = 9'h1ff;

    // Frame layout
    localparam logic [3:0] STALE_BITS  = 4'h9;
    localparam logic [3:0] FRAME_LOAD  = 4'h8;
    localparam logic [3:0] NULL_SLOT   = 4'h1;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_LOW_NS    = 500;
    // Low must last longer than the limit: round up past it
    localparam int SCL_LOW_CYC   = SCL_LOW_NS / CLK_PERIOD_NS + 1;

    typedef enum logic [1:0] {
        MODE_DDC1   = 2'b00,
        MODE_SLAVE  = 2'b01,
        MODE_MASTER = 2'b10
    } ddcl_mode_type;
endpackage

/* File: rtl/ddcl_pin_if.sv */
// Interface: conditioned pin events passed from the pin front end to the channel core
`timescale 1ns/100ps
`default_nettype none
interface ddcl_pin_if;
    logic vsync_rise;
    logic scl_low_long;
    logic sda_level;
    logic scl_level;
    modport prod (output vsync_rise, output scl_low_long, output sda_level, output scl_level);
    modport cons (input vsync_rise, input scl_low_long, input sda_level, input scl_level);
endinterface
`default_nettype wire

/* File: rtl/ddcl_pin_sync.sv */
// Pin front end: synchronisers, Vsync rise detection and SCL low-pulse filter
`timescale 1ns/100ps
`default_nettype none
module ddcl_pin_sync (
    input  wire logic   clock,
    input  wire logic   reset_n,
    input  wire logic   vsync_pin,
    input  wire logic   scl_pin,
    input  wire logic   sda_pin,
    ddcl_pin_if.prod    pins
);
    logic [2:0] meta_q, meta_d;
    logic [2:0] sync_q, sync_d;
    logic       vs_last_q, vs_last_d;
    logic [6:0] low_cnt_q, low_cnt_d;
    logic       rise_q, rise_d;
    logic       long_q, long_d;

    localparam logic [6:0] LOW_LIMIT = 7'(ddcl_pkg::SCL_LOW_CYC);

    always_comb begin
        meta_d    = {vsync_pin, scl_pin, sda_pin};
        sync_d    = meta_q;
        vs_last_d = sync_q[2];
        rise_d    = sync_q[2] & ~vs_last_q;
        low_cnt_d = low_cnt_q;
        long_d    = 1'b0;
        if (sync_q[1]) begin
            low_cnt_d = 7'h00;
        end else if (low_cnt_q != LOW_LIMIT) begin
            low_cnt_d = low_cnt_q + 7'h01;
        end
        if (!sync_q[1] && low_cnt_q == LOW_LIMIT - 7'h01) begin
            long_d = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_q    <= 3'h7;
            sync_q    <= 3'h7;
            vs_last_q <= 1'b1;
            low_cnt_q <= 7'h00;
            rise_q    <= 1'b0;
            long_q    <= 1'b0;
        end else begin
            meta_q    <= meta_d;
            sync_q    <= sync_d;
            vs_last_q <= vs_last_d;
            low_cnt_q <= low_cnt_d;
            rise_q    <= rise_d;
            long_q    <= long_d;
        end
    end

    assign pins.vsync_rise   = rise_q;
    assign pins.scl_low_long = long_q;
    assign pins.scl_level    = sync_q[1];
    assign pins.sda_level    = sync_q[0];
endmodule
`default_nettype wire

/* File: rtl/ddcl_top.sv */
// Display data channel: Wishbone registers, mode control and DDC1 transmit path
// Contract
// - After reset pins act as GPIO; bus behaviour only after enable bit written zero.
// - Enabling starts the channel in DDC1 mode; reset also leaves it in DDC1.
// - In DDC1, SCL low longer than 500ns switches automatically to DDC2B+.
// - Writing master-select zero in DDC1 enters master mode directly, skipping slave.
// - Writing one to the return bit goes back from DDC2B+ to DDC1.
// - In DDC1 Vsync is the bit clock and data leaves on SDA only.
// - Transmit path: writable preload byte plus hidden shift register.
// - First nine Vsync rises after enable shift out stale shift contents.
// - Next rise loads preload, outputs MSB immediately, raises transmit interrupt.
// - Eight bits go out MSB first; the ninth edge sends a null one.
// - Rise after null bit reloads, raises interrupt again, repeating the frame.
// - Without a new byte the previous byte is sent again unchanged.
// - Vsync clocks DDC1 only in separate sync mode, at most 25KHz.
// - In composite sync mode nothing is sent on SDA.
// - Change from DDC1 to slave raises the SCL go-low interrupt.
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ddcl_top (
    input  wire logic        CLOCK,
    input  wire logic        RESET_N,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        VSYNC_I,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE,
    input  wire logic        SCL_I,
    output logic             SCL_O,
    output logic             SCL_OE,
    output logic             IRQ
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin front end
    ddcl_pin_if pins ();

    ddcl_pin_sync u_pins (
        .clock     (CLOCK),
        .reset_n   (RESET_N),
        .vsync_pin (VSYNC_I),
        .scl_pin   (SCL_I),
        .sda_pin   (SDA_I),
        .pins      (pins.prod)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait-free answer a cycle after the request
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic        req;
    logic        wr_lane;

    ddcl_pkg::ddcl_mode_type mode_q, mode_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] clksel_q, clksel_d;
    logic [7:0] tx_preload_buffer_q, tx_preload_buffer_d;
    logic [1:0] irq_stat_q, irq_stat_d;
    logic [1:0] irq_enable_reg_q, irq_enable_reg_d;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction

    assign req     = WB_CYC_I & WB_STB_I & ~ack_q;
    assign wr_lane = req & WB_WE_I & WB_SEL_I[0];

    always_comb begin
        ack_d  = req;
        rdat_d = 32'h0000_0000;
        if (req && !WB_WE_I) begin
            if (hit(WB_ADR_I, ddcl_pkg::OFS_CTRL)) begin
                rdat_d[7:0] = ctrl_q;
            end else if (hit(WB_ADR_I, ddcl_pkg::OFS_CLKSEL)) begin
                rdat_d[7:0] = clksel_q;
            end else if (hit(WB_ADR_I, ddcl_pkg::OFS_TXDATA)) begin
                rdat_d[7:0] = tx_preload_buffer_q;
            end else if (hit(WB_ADR_I, ddcl_pkg::OFS_IRQSTAT)) begin
                rdat_d[1:0] = irq_stat_q;
            end else if (hit(WB_ADR_I, ddcl_pkg::OFS_IRQEN)) begin
                rdat_d[1:0] = irq_enable_reg_q;
            end else if (hit(WB_ADR_I, ddcl_pkg::OFS_STATUS)) begin
                rdat_d[ddcl_pkg::ST_MODE_LO +: 2] = mode_q;
                rdat_d[ddcl_pkg::ST_SDA_IN]       = pins.sda_level;
                rdat_d[ddcl_pkg::ST_SCL_IN]       = pins.scl_level;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file
    logic wr_ctrl, wr_clk, wr_tx, wr_stat, wr_en;
    logic en_start;
    logic ret_wr;
    logic master_wr0;
    logic tx_set, scl_set;
    logic enable_n;

    assign wr_ctrl    = wr_lane & hit(WB_ADR_I, ddcl_pkg::OFS_CTRL);
    assign wr_clk     = wr_lane & hit(WB_ADR_I, ddcl_pkg::OFS_CLKSEL);
    assign wr_tx      = wr_lane & hit(WB_ADR_I, ddcl_pkg::OFS_TXDATA);
    assign wr_stat    = wr_lane & hit(WB_ADR_I, ddcl_pkg::OFS_IRQSTAT);
    assign wr_en      = wr_lane & hit(WB_ADR_I, ddcl_pkg::OFS_IRQEN);
    assign enable_n   = ctrl_q[ddcl_pkg::CTRL_ENABLE_N];
    assign en_start   = wr_ctrl & enable_n & ~WB_DAT_I[ddcl_pkg::CTRL_ENABLE_N];
    assign ret_wr     = wr_ctrl & WB_DAT_I[ddcl_pkg::CTRL_RETURN];
    assign master_wr0 = wr_clk & ~WB_DAT_I[ddcl_pkg::CLK_MASTER_N];

    always_comb begin
        ctrl_d              = ctrl_q;
        clksel_d            = clksel_q;
        tx_preload_buffer_d = tx_preload_buffer_q;
        irq_enable_reg_d    = irq_enable_reg_q;
        irq_stat_d          = irq_stat_q;
        if (wr_ctrl) begin
            ctrl_d = WB_DAT_I[7:0];
        end
        // Return request acts once and never reads back as set
        ctrl_d[ddcl_pkg::CTRL_RETURN] = 1'b0;
        if (wr_clk) begin
            clksel_d = WB_DAT_I[7:0];
        end
        if (wr_tx) begin
            tx_preload_buffer_d = WB_DAT_I[7:0];
        end
        if (wr_en) begin
            irq_enable_reg_d = WB_DAT_I[1:0];
        end
        if (wr_stat) begin
            irq_stat_d = irq_stat_q & ~WB_DAT_I[1:0];
        end
        // Hardware set beats a simultaneous write-one clear
        irq_stat_d[ddcl_pkg::IRQ_TX]  = irq_stat_d[ddcl_pkg::IRQ_TX] | tx_set;
        irq_stat_d[ddcl_pkg::IRQ_SCL] = irq_stat_d[ddcl_pkg::IRQ_SCL] | scl_set;
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_q              <= ddcl_pkg::CTRL_RST;
            clksel_q            <= ddcl_pkg::CLKSEL_RST;
            tx_preload_buffer_q <= ddcl_pkg::TXDATA_RST;
            irq_stat_q          <= ddcl_pkg::IRQ_RST;
            irq_enable_reg_q    <= ddcl_pkg::IRQ_RST;
        end else begin
            ctrl_q              <= ctrl_d;
            clksel_q            <= clksel_d;
            tx_preload_buffer_q <= tx_preload_buffer_d;
            irq_stat_q          <= irq_stat_d;
            irq_enable_reg_q    <= irq_enable_reg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel mode
    always_comb begin
        mode_d = mode_q;
        if (enable_n) begin
            mode_d = ddcl_pkg::MODE_DDC1;
        end else begin
            case (mode_q)
                ddcl_pkg::MODE_DDC1: begin
                    if (master_wr0) begin
                        mode_d = ddcl_pkg::MODE_MASTER;
                    end else if (pins.scl_low_long) begin
                        mode_d = ddcl_pkg::MODE_SLAVE;
                    end
                end
                ddcl_pkg::MODE_SLAVE: begin
                    if (ret_wr) begin
                        mode_d = ddcl_pkg::MODE_DDC1;
                    end else if (master_wr0) begin
                        mode_d = ddcl_pkg::MODE_MASTER;
                    end
                end
                ddcl_pkg::MODE_MASTER: begin
                    if (ret_wr) begin
                        mode_d = ddcl_pkg::MODE_DDC1;
                    end
                end
                default: begin
                    mode_d = ddcl_pkg::MODE_DDC1;
                end
            endcase
        end
    end

    assign scl_set = (mode_q == ddcl_pkg::MODE_DDC1) && (mode_d == ddcl_pkg::MODE_SLAVE);

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_q <= ddcl_pkg::MODE_DDC1;
        end else begin
            mode_q <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // DDC1 transmit path: hidden shift register clocked by Vsync rises
    logic [8:0] shift_q, shift_d;
    logic [3:0] left_q, left_d;
    logic       bit_q, bit_d;
    logic       ddc1_active;
    logic       tx_step;
    logic       sda_oe_q, sda_oe_d;
    logic       scl_oe_q, scl_oe_d;
    logic       irq_q, irq_d;

    // Composite sync gives no usable Vsync clock, so the path stands still
    assign ddc1_active = ~enable_n & (mode_q == ddcl_pkg::MODE_DDC1)
                         & ctrl_q[ddcl_pkg::CTRL_SYNC_SEP];
    assign tx_step     = ddc1_active & pins.vsync_rise;
    assign tx_set      = tx_step & (left_q == 4'h0);

    always_comb begin
        shift_d = shift_q;
        left_d  = left_q;
        bit_d   = bit_q;
        if (en_start) begin
            left_d = ddcl_pkg::STALE_BITS;
            bit_d  = 1'b1;
        end else if (tx_step) begin
            if (left_q == 4'h0) begin
                // Same byte goes again if software wrote nothing new
                bit_d   = tx_preload_buffer_q[7];
                shift_d = {tx_preload_buffer_q[6:0], 2'b11};
                left_d  = ddcl_pkg::FRAME_LOAD;
            end else begin
                bit_d   = shift_q[8];
                shift_d = {shift_q[7:0], 1'b1};
                left_d  = left_q - 4'h1;
            end
        end
        // Drive low for zero only; ones leave the line to the pull-up
        if (enable_n) begin
            sda_oe_d = ctrl_q[ddcl_pkg::CTRL_GPIO_SDA];
            scl_oe_d = ctrl_q[ddcl_pkg::CTRL_GPIO_SCL];
        end else begin
            sda_oe_d = ddc1_active & ~bit_d;
            scl_oe_d = 1'b0;
        end
        irq_d = |(irq_stat_q & irq_enable_reg_q);
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            shift_q  <= ddcl_pkg::SHIFT_RST;
            left_q   <= ddcl_pkg::STALE_BITS;
            bit_q    <= 1'b1;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            shift_q  <= shift_d;
            left_q   <= left_d;
            bit_q    <= bit_d;
            sda_oe_q <= sda_oe_d;
            scl_oe_q <= scl_oe_d;
            irq_q    <= irq_d;
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdat_q;
    assign SDA_OE   = sda_oe_q;
    assign SCL_OE   = scl_oe_q;
    assign IRQ      = irq_q;

    // Open-drain pins only ever pull low
    logic zero_q;
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            zero_q <= 1'b0;
        end else begin
            zero_q <= 1'b0;
        end
    end
    assign SDA_O = zero_q;
    assign SCL_O = zero_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_disabled_gpio;
        @(posedge CLOCK) disable iff (!RESET_N)
        enable_n |=> (SDA_OE == $past(ctrl_q[ddcl_pkg::CTRL_GPIO_SDA]));
    endproperty
    a_disabled_gpio: assert property (p_disabled_gpio) else $error("gpio drive wrong");

    property p_enable_ddc1;
        @(posedge CLOCK) disable iff (!RESET_N)
        en_start |=> (mode_q == ddcl_pkg::MODE_DDC1) && (left_q == ddcl_pkg::STALE_BITS);
    endproperty
    a_enable_ddc1: assert property (p_enable_ddc1) else $error("enable not in ddc1");

    property p_scl_slave;
        @(posedge CLOCK) disable iff (!RESET_N)
        (!enable_n && mode_q == ddcl_pkg::MODE_DDC1 && pins.scl_low_long && !master_wr0)
        |=> (mode_q == ddcl_pkg::MODE_SLAVE) ##1 irq_stat_q[ddcl_pkg::IRQ_SCL];
    endproperty
    a_scl_slave: assert property (p_scl_slave) else $error("no slave switch");

    property p_master;
        @(posedge CLOCK) disable iff (!RESET_N)
        (!enable_n && mode_q == ddcl_pkg::MODE_DDC1 && master_wr0)
        |=> (mode_q == ddcl_pkg::MODE_MASTER);
    endproperty
    a_master: assert property (p_master) else $error("no master entry");

    property p_return;
        @(posedge CLOCK) disable iff (!RESET_N)
        (ret_wr && mode_q != ddcl_pkg::MODE_DDC1) |=> (mode_q == ddcl_pkg::MODE_DDC1);
    endproperty
    a_return: assert property (p_return) else $error("no return to ddc1");

    property p_load_msb;
        @(posedge CLOCK) disable iff (!RESET_N)
        (tx_set && !en_start) |=> (SDA_OE == !$past(tx_preload_buffer_q[7]))
            && irq_stat_q[ddcl_pkg::IRQ_TX] && (left_q == ddcl_pkg::FRAME_LOAD);
    endproperty
    a_load_msb: assert property (p_load_msb) else $error("load or irq wrong");

    property p_null_bit;
        @(posedge CLOCK) disable iff (!RESET_N)
        (tx_step && !en_start && left_q == ddcl_pkg::NULL_SLOT) |=> !SDA_OE && left_q == 4'h0;
    endproperty
    a_null_bit: assert property (p_null_bit) else $error("null bit not one");

    property p_composite;
        @(posedge CLOCK) disable iff (!RESET_N)
        (!enable_n && !ctrl_q[ddcl_pkg::CTRL_SYNC_SEP]) |=> !SDA_OE && $stable(left_q);
    endproperty
    a_composite: assert property (p_composite) else $error("sent in composite");

    property p_irq_out;
        @(posedge CLOCK) disable iff (!RESET_N)
        (|(irq_stat_q & irq_enable_reg_q)) |=> IRQ;
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("irq not raised");

    property p_ack;
        @(posedge CLOCK) disable iff (!RESET_N)
        (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");
endmodule
`default_nettype wire

/* File: tb/ddcl_host_model.sv */
// Host graphics adapter model: drives Vsync bit clock and pulls SCL low
`timescale 1ns/100ps
`default_nettype none
module ddcl_host_model (
    input  wire logic clock,
    output logic      vsync,
    output logic      scl_drive_n
);
    initial begin
        vsync       = 1'b0;
        scl_drive_n = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // One 64 ns link clock period; Vsync then rests low between calls
    task automatic vsync_rise();
        // Called on a clock edge: back-to-back calls give an eight-clock period
        vsync <= 1'b1;
        repeat (4) @(posedge clock);
        vsync <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    // SCL held low for n clocks, then released to the pull-up
    task automatic scl_low(input int n);
        @(posedge clock);
        scl_drive_n <= 1'b0;
        repeat (n) @(posedge clock);
        scl_drive_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_ddc_channel_link.sv */
// Testbench: registers, DDC1 framing, sync mode gating and mode changes
`timescale 1ns/100ps
`default_nettype none
module tb_ddc_channel_link;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        sda_o, sda_oe, scl_o, scl_oe, irq;
    logic        vsync, scl_drive_n;
    logic        sda_line, scl_line;
    int          fails = 0;
    int          n_tests = 0;

    // Open-drain lines with pull-ups
    assign sda_line = ~sda_oe;
    assign scl_line = ~scl_oe & scl_drive_n;

    always #4 clock = ~clock;

    ddcl_top dut (
        .CLOCK(clock), .RESET_N(reset_n), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
        .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_wdat),
        .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack), .VSYNC_I(vsync), .SDA_I(sda_line),
        .SDA_O(sda_o), .SDA_OE(sda_oe), .SCL_I(scl_line), .SCL_O(scl_o),
        .SCL_OE(scl_oe), .IRQ(irq)
    );
    ddcl_host_model host (.clock(clock), .vsync(vsync), .scl_drive_n(scl_drive_n));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Classic single cycle: hold until ack, take data at that edge, then release
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= adr;
        wb_sel  <= 4'hf;
        wb_wdat <= wd;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_rdat;
        if (n >= 50) chk("wb_ack", 32'h1, 32'h0);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] rd;
        wb(1'b1, adr, d, rd);
    endtask

    task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb(1'b0, adr, 32'h0, rd);
        chk(name, exp, rd);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        rdchk("ctrl", ddcl_pkg::OFS_CTRL, 32'h81);
        rdchk("clksel", ddcl_pkg::OFS_CLKSEL, 32'hff);
        rdchk("txdata", ddcl_pkg::OFS_TXDATA, 32'h00);
        rdchk("irqstat", ddcl_pkg::OFS_IRQSTAT, 32'h00);
        rdchk("mode", ddcl_pkg::OFS_STATUS, 32'h30);
        rdchk("unmapped", 8'h18, 32'h00);
        chk("irq", 32'h0, {31'h0, irq});
    endtask

    // Disabled channel: pins are plain pull-low outputs, no DDC1 stepping
    task automatic t_gpio();
        wr(ddcl_pkg::OFS_CTRL, 32'h87);
        repeat (2) @(posedge clock);
        chk("sda_oe", 32'h1, {31'h0, sda_oe});
        chk("scl_oe", 32'h1, {31'h0, scl_oe});
        chk("pin_out_levels", 32'h0, {30'h0, sda_o, scl_o});
        wr(ddcl_pkg::OFS_CTRL, 32'h81);
        host.vsync_rise();
        chk("sda_oe", 32'h0, {31'h0, sda_oe});
    endtask

    // Nine rises, MSB first then null one; interrupt on the load rise
    task automatic frame(input logic [7:0] b);
        logic [8:0] f;
        f = {b, 1'b1};
        for (int i = 0; i < 9; i++) begin
            host.vsync_rise();
            chk("sda_bit", {31'h0, f[8-i]}, {31'h0, sda_line});
            if (i == 0) begin
                rdchk("tx_irq", ddcl_pkg::OFS_IRQSTAT, 32'h1);
                chk("irq", 32'h1, {31'h0, irq});
                wr(ddcl_pkg::OFS_IRQSTAT, 32'h1);
                repeat (2) @(posedge clock);
                chk("irq_clr", 32'h0, {31'h0, irq});
            end
        end
    endtask

    task automatic t_ddc1_stream();
        wr(ddcl_pkg::OFS_TXDATA, 32'ha5);
        wr(ddcl_pkg::OFS_CTRL, 32'h01);
        wr(ddcl_pkg::OFS_IRQEN, 32'h1);
        for (int i = 0; i < 9; i++) begin
            host.vsync_rise();
            chk("stale", 32'h1, {31'h0, sda_line});
            chk("irq_stale", 32'h0, {31'h0, irq});
        end
        frame(8'ha5);
        wr(ddcl_pkg::OFS_TXDATA, 32'h3c);
        frame(8'h3c);
        frame(8'h3c);
        chk("scl_oe", 32'h0, {31'h0, scl_oe});
    endtask

    // Composite sync: preload byte holds zeros yet SDA stays released
    task automatic t_composite();
        wr(ddcl_pkg::OFS_TXDATA, 32'h00);
        wr(ddcl_pkg::OFS_CTRL, 32'h00);
        for (int i = 0; i < 10; i++) begin
            host.vsync_rise();
            chk("sda_comp", 32'h0, {31'h0, sda_oe});
        end
        wr(ddcl_pkg::OFS_CTRL, 32'h01);
        wr(ddcl_pkg::OFS_IRQSTAT, 32'h3);
    endtask

    task automatic t_modes();
        host.scl_low(40);
        rdchk("short_low", ddcl_pkg::OFS_STATUS, 32'h30);
        host.scl_low(75);
        rdchk("to_slave", ddcl_pkg::OFS_STATUS, 32'h31);
        rdchk("scl_irq", ddcl_pkg::OFS_IRQSTAT, 32'h2);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(ddcl_pkg::OFS_IRQEN, 32'h2);
        repeat (2) @(posedge clock);
        chk("irq_scl", 32'h1, {31'h0, irq});
        wr(ddcl_pkg::OFS_IRQSTAT, 32'h2);
        wr(ddcl_pkg::OFS_CTRL, 32'h41);
        rdchk("return", ddcl_pkg::OFS_STATUS, 32'h30);
        wr(ddcl_pkg::OFS_CLKSEL, 32'h7f);
        rdchk("master", ddcl_pkg::OFS_STATUS, 32'h32);
        rdchk("no_slave", ddcl_pkg::OFS_IRQSTAT, 32'h0);
        wr(ddcl_pkg::OFS_CTRL, 32'h41);
        rdchk("return2", ddcl_pkg::OFS_STATUS, 32'h30);
        host.scl_low(75);
        rdchk("to_slave2", ddcl_pkg::OFS_STATUS, 32'h31);
        wr(ddcl_pkg::OFS_CLKSEL, 32'h7f);
        rdchk("slave_master", ddcl_pkg::OFS_STATUS, 32'h32);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        t_reset_values();
        t_gpio();
        t_ddc1_stream();
        t_composite();
        t_modes();
        give_verdict();
    end

    // Run needs well under 10k clocks
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule
`default_nettype wire
